// *** verilog/intc_pkg.sv ***
// Purpose: Shared constants and types for the vectored interrupt controller and its core end.
// Assumes: Ten sources in fixed query order, two priority levels, 16-bit program counter.
// Notes: Flag bit 10 is the second serial flag; sources use bits 9:0.
`default_nettype none
package intc_pkg;
    localparam int NUM_SRC = 10;
    localparam int FLAG_W = 11;
    localparam int PIN_W = 14;
    localparam int SRC_W = 4;
    localparam int VEC_W = 16;
    localparam int EV_W = 3;
    localparam int ADDR_W = 8;
    // Source indices in query order
    localparam logic [SRC_W-1:0] SRC_EXT0 = 4'h0;
    localparam logic [SRC_W-1:0] SRC_TMR0 = 4'h1;
    localparam logic [SRC_W-1:0] SRC_EXT1 = 4'h2;
    localparam logic [SRC_W-1:0] SRC_TMR1 = 4'h3;
    localparam logic [SRC_W-1:0] SRC_UART = 4'h4;
    localparam logic [SRC_W-1:0] SRC_TMR2 = 4'h5;
    localparam logic [SRC_W-1:0] SRC_ADC = 4'h6;
    localparam logic [SRC_W-1:0] SRC_PWM = 4'h7;
    localparam logic [SRC_W-1:0] SRC_BTM = 4'h8;
    localparam logic [SRC_W-1:0] SRC_EXT2 = 4'h9;
    localparam logic [SRC_W-1:0] FLAG_UART_TX = 4'ha;
    localparam int GLOBAL_EN_BIT = 10;
    // Pin fields inside the 14-bit pin and edge-select vectors
    localparam int G0_LO = 0;
    localparam int G0_HI = 3;
    localparam int G1_LO = 4;
    localparam int G1_HI = 7;
    localparam int G2_LO = 8;
    localparam int G2_HI = 13;
    // Vectors indexed by source
    localparam logic [VEC_W-1:0] VEC_TAB [NUM_SRC] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
                                                       16'h002b, 16'h0033, 16'h0043, 16'h004b, 16'h0053};
    // Flags cleared by hardware on acceptance (all three externals, timers 0/1, pwm, base tick)
    localparam logic [FLAG_W-1:0] HW_CLR_MASK = 11'h38f;
    // Sources allowed to wake from stop
    localparam logic [NUM_SRC-1:0] WAKE_MASK = 10'h305;
    // In-service bit positions
    localparam int INS_LO = 0;
    localparam int INS_HI = 1;
    // Event status bits
    localparam int EV_WAKE = 0;
    localparam int EV_ACCEPT = 1;
    localparam int EV_RETURN = 2;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PRIORITY = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RISE_SEL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FALL_SEL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IN_SERVICE = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EV_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_EV_CLEAR = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_EV_ENABLE = 8'h20;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    // Core-end sequencer states, gray along the accept path
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_PUSH = 2'h1,
        ST_LOAD = 2'h3
    } core_state_e;
endpackage
`default_nettype wire

// *** verilog/intc_link_if.sv ***
// Purpose: Link between the interrupt controller and the core sequencer.
// Assumes: One clock; every signal driven from a flip-flop of its sender.
// Notes: ack, return_from_interrupt and instr_done are one-cycle pulses; req/vec/src/hi are levels.
`default_nettype none
interface intc_link_if
    import intc_pkg::*;
();
    logic req;
    logic hi;
    logic [SRC_W-1:0] src;
    logic [VEC_W-1:0] vec;
    logic ack;
    logic ack_hi;
    logic [SRC_W-1:0] ack_src;
    logic return_from_interrupt;
    logic instr_done;
    modport ctrl (output req, output hi, output src, output vec,
                  input ack, input ack_hi, input ack_src, input return_from_interrupt, input instr_done);
    modport core (input req, input hi, input src, input vec,
                  output ack, output ack_hi, output ack_src, output return_from_interrupt, output instr_done);
endinterface
`default_nettype wire

// *** verilog/intc_core_end.sv ***
// Purpose: Core-side sequencer: takes offered interrupts at instruction boundaries.
// Assumes: return_from_interrupt_exec is pulsed together with the instr_done of the return instruction.
// Notes: Core stalls between acceptance and vector load; pc_now is valid with instr_done.
`default_nettype none
module intc_core_end
    import intc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    intc_link_if.core link,
    input wire logic instr_done,
    input wire logic return_from_interrupt_exec,
    input wire logic [VEC_W-1:0] pc_now,
    output logic stack_push,
    output logic [VEC_W-1:0] stack_push_pc,
    output logic pc_load,
    output logic [VEC_W-1:0] pc_load_vec
);
    typedef struct packed {
        core_state_e st;
        logic [VEC_W-1:0] vec;
        logic [SRC_W-1:0] src;
        logic hi;
        logic push;
        logic [VEC_W-1:0] push_pc;
        logic load;
        logic ack;
        logic return_from_interrupt;
        logic done;
    } core_s;

    core_s q;
    core_s d;

    // Sequencer and pulse generation
    always_comb
    begin
        d = q;
        d.push = 1'b0;
        d.load = 1'b0;
        d.ack = 1'b0;
        d.return_from_interrupt = return_from_interrupt_exec;
        d.done = instr_done;
        unique case (q.st)
            ST_IDLE:
            begin
                if (instr_done && !return_from_interrupt_exec && link.req)
                begin
                    d.st = ST_PUSH;
                    d.vec = link.vec;
                    d.src = link.src;
                    d.hi = link.hi;
                    d.push = 1'b1;
                    d.push_pc = pc_now;
                end
            end
            ST_PUSH:
            begin
                d.st = ST_LOAD;
                d.load = 1'b1;
                d.ack = 1'b1;
            end
            ST_LOAD:
            begin
                d.st = ST_IDLE;
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign stack_push = q.push;
    assign stack_push_pc = q.push_pc;
    assign pc_load = q.load;
    assign pc_load_vec = q.vec;
    assign link.ack = q.ack;
    assign link.ack_hi = q.hi;
    assign link.ack_src = q.src;
    assign link.return_from_interrupt = q.return_from_interrupt;
    assign link.instr_done = q.done;
endmodule // intc_core_end
`default_nettype wire

// *** verilog/intc_ctrl.sv ***
// Purpose: Two-level vectored interrupt controller for ten sources, AHB-Lite configured.
// Assumes: Peripheral event inputs are one-cycle pulses synchronous to hclk; pins synchronous.
// Notes: Reads take one wait state; writes take none. Unmapped reads return zero.
`default_nettype none
module intc_ctrl
    import intc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    intc_link_if.ctrl link,
    input wire logic [G0_HI-G0_LO:0] ext_group0,
    input wire logic [G1_HI-G1_LO:0] ext_group1,
    input wire logic [G2_HI-G2_LO:0] ext_group2,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic uart_rx_done,
    input wire logic uart_tx_done,
    input wire logic adc_start,
    input wire logic adc_done,
    input wire logic pwm_period_pass,
    input wire logic base_tick_ovf,
    input wire logic stop_mode,
    output logic wake_req,
    output logic irq
);
    typedef struct packed {
        logic [FLAG_W-1:0] en;
        logic [NUM_SRC-1:0] pri;
        logic [PIN_W-1:0] rise;
        logic [PIN_W-1:0] fall;
        logic [FLAG_W-1:0] flag;
        logic [PIN_W-1:0] pin_prev;
        logic [1:0] ins;
        logic hold;
        logic req;
        logic hi;
        logic [SRC_W-1:0] src;
        logic [VEC_W-1:0] vec;
        logic wake;
        logic [EV_W-1:0] ev_stat;
        logic [EV_W-1:0] ev_en;
        logic irq;
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic rdy;
        logic [31:0] rdata;
    } ctrl_s;

    ctrl_s q;
    ctrl_s d;

    // Lowest set index of a request vector
    function automatic logic [SRC_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = SRC_W'(i);
            end
        end
        return r;
    endfunction

    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] edges;
    logic [FLAG_W-1:0] fset;
    logic [FLAG_W-1:0] fclr;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] act;
    logic [NUM_SRC-1:0] act_hi;
    logic [NUM_SRC-1:0] act_lo;
    logic ok_hi;
    logic ok_lo;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [31:0] rd_word;

    // Flags, arbitration, events and bus slave
    always_comb
    begin
        d = q;
        pins = {ext_group2, ext_group1, ext_group0};
        edges = (pins & ~q.pin_prev & q.rise) | (~pins & q.pin_prev & q.fall);
        d.pin_prev = pins;

        fset = '0;
        fset[SRC_EXT0] = |edges[G0_HI:G0_LO];
        fset[SRC_EXT1] = |edges[G1_HI:G1_LO];
        fset[SRC_EXT2] = |edges[G2_HI:G2_LO];
        fset[SRC_TMR0] = timer0_ovf;
        fset[SRC_TMR1] = timer1_ovf;
        fset[SRC_TMR2] = timer2_ovf;
        fset[SRC_UART] = uart_rx_done;
        fset[FLAG_UART_TX] = uart_tx_done;
        fset[SRC_ADC] = adc_done;
        fset[SRC_PWM] = pwm_period_pass;
        fset[SRC_BTM] = base_tick_ovf;

        fclr = '0;
        // hardware clear on acceptance; excluded by mask
        if (link.ack)
        begin
            fclr[link.ack_src] = HW_CLR_MASK[link.ack_src];
        end
        if (adc_start)
        begin
            fclr[SRC_ADC] = 1'b1;
        end
        if (q.wr && q.addr == OFF_FLAGS)
        begin
            fclr = fclr | hwdata[FLAG_W-1:0];
        end
        d.flag = (q.flag & ~fclr) | fset;

        pend = q.flag[NUM_SRC-1:0];
        pend[SRC_UART] = q.flag[SRC_UART] | q.flag[FLAG_UART_TX];
        act = pend & q.en[NUM_SRC-1:0] & {NUM_SRC{q.en[GLOBAL_EN_BIT]}};
        act_hi = act & q.pri;
        act_lo = act & ~q.pri;
        ok_hi = (|act_hi) && !q.ins[INS_HI];
        ok_lo = (|act_lo) && (q.ins == 2'h0);

        // in-service bits: return clears highest, acceptance sets
        if (link.return_from_interrupt)
        begin
            if (q.ins[INS_HI])
            begin
                d.ins[INS_HI] = 1'b0;
            end
            else
            begin
                d.ins[INS_LO] = 1'b0;
            end
        end
        if (link.ack)
        begin
            d.ins[link.ack_hi ? INS_HI : INS_LO] = 1'b1;
        end
        if (link.instr_done)
        begin
            d.hold = 1'b0;
        end
        if (link.return_from_interrupt)
        begin
            d.hold = 1'b1;
        end

        d.hi = ok_hi;
        d.src = ok_hi ? first_set(act_hi) : first_set(act_lo);
        d.vec = VEC_TAB[d.src];
        d.req = !q.hold && !link.ack && !link.return_from_interrupt && (ok_hi || ok_lo);

        d.wake = stop_mode && (|(pend & q.en[NUM_SRC-1:0] & WAKE_MASK));

        // Sticky events, write-only clear
        ev_set = '0;
        ev_set[EV_WAKE] = d.wake && !q.wake;
        ev_set[EV_ACCEPT] = link.ack;
        ev_set[EV_RETURN] = link.return_from_interrupt;
        ev_clr = '0;
        if (q.wr && q.addr == OFF_EV_CLEAR)
        begin
            ev_clr = hwdata[EV_W-1:0];
        end
        d.ev_stat = (q.ev_stat & ~ev_clr) | ev_set;
        d.irq = |(d.ev_stat & q.ev_en);

        // Register writes in data phase
        d.wr = 1'b0;
        if (q.wr)
        begin
            case (q.addr)
                OFF_ENABLE: d.en = hwdata[FLAG_W-1:0];
                OFF_PRIORITY: d.pri = hwdata[NUM_SRC-1:0];
                OFF_RISE_SEL: d.rise = hwdata[PIN_W-1:0];
                OFF_FALL_SEL: d.fall = hwdata[PIN_W-1:0];
                OFF_EV_ENABLE: d.ev_en = hwdata[EV_W-1:0];
                default: d.en = q.en;
            endcase
        end

        // Read mux, sampled in the wait cycle
        case (q.addr)
            OFF_ENABLE: rd_word = 32'(q.en);
            OFF_PRIORITY: rd_word = 32'(q.pri);
            OFF_RISE_SEL: rd_word = 32'(q.rise);
            OFF_FALL_SEL: rd_word = 32'(q.fall);
            OFF_FLAGS: rd_word = 32'(q.flag);
            OFF_IN_SERVICE: rd_word = 32'(q.ins);
            OFF_EV_STATUS: rd_word = 32'(q.ev_stat);
            OFF_EV_ENABLE: rd_word = 32'(q.ev_en);
            default: rd_word = '0;
        endcase
        if (q.rd)
        begin
            d.rdata = rd_word;
            d.rd = 1'b0;
            d.rdy = 1'b1;
        end

        // Address phase capture
        if (hsel && htrans == HTRANS_NONSEQ && hready)
        begin
            d.addr = haddr[ADDR_W-1:0];
            d.wr = hwrite;
            d.rd = !hwrite;
            d.rdy = hwrite;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.rdy <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flops; hresp tied to HRESP_OKAY
    assign hreadyout = q.rdy;
    assign hresp = HRESP_OKAY;
    assign hrdata = q.rdata;
    assign link.req = q.req;
    assign link.hi = q.hi;
    assign link.src = q.src;
    assign link.vec = q.vec;
    assign wake_req = q.wake;
    assign irq = q.irq;
endmodule // intc_ctrl
`default_nettype wire

// *** verification/intc_link_monitor.sv ***
// Purpose: Checker on the link between controller and core end.
// Assumes: Sees only the link signals, one clock domain.
// Notes: Keeps its own copy of the two in-service levels.
`default_nettype none
module intc_link_monitor
    import intc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire logic hi,
    input wire logic [SRC_W-1:0] src,
    input wire logic [VEC_W-1:0] vec,
    input wire logic ack,
    input wire logic ack_hi,
    input wire logic return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ins_q;
    logic [1:0] ins_d;
    // Shadow levels: set on ack, return ends the top one
    always_comb
    begin
        ins_d = ins_q;
        if (ack)
            ins_d[ack_hi] = 1'b1;
        else if (return_from_interrupt)
            ins_d = ins_q[1] ? {1'b0, ins_q[0]} : 2'b00;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ins_q <= 2'b00;
        else
            ins_q <= ins_d;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_vec;
        req |-> vec == VEC_TAB[src];
    endproperty
    a_vec: assert property (p_vec) else $error("offered vector wrong");
    property p_hi_block;
        ack && ack_hi |-> !ins_q[1];
    endproperty
    a_hi_block: assert property (p_hi_block) else $error("high taken twice");
    property p_low_block;
        ack && !ack_hi |-> ins_q == 2'b00;
    endproperty
    a_low_block: assert property (p_low_block) else $error("low taken while busy");
    property p_offer;
        req |-> !ins_q[1] && (hi || !ins_q[0]);
    endproperty
    a_offer: assert property (p_offer) else $error("offer not above level");
    property p_cause;
        ack |-> $past(req, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("ack without offer");
    property p_gap;
        ack |=> !ack [*2];
    endproperty
    a_gap: assert property (p_gap) else $error("acks too close");
    property p_drop;
        ack |=> !req;
    endproperty
    a_drop: assert property (p_drop) else $error("offer kept after ack");
    property p_hold;
        return_from_interrupt |=> !req;
    endproperty
    a_hold: assert property (p_hold) else $error("offer right after return");
endmodule // intc_link_monitor
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Bench for controller and core end joined by the link.
// Assumes: Bench issues one instruction at most every third cycle.
// Notes: Registers reached by single word AHB-Lite transfers.
`default_nettype none
module tb
    import intc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [13:0] pins = 14'h0;
    logic [8:0] pls = 9'h0;
    logic stop_mode = 1'b0;
    logic instr_done = 1'b0;
    logic return_from_interrupt_exec = 1'b0;
    logic [15:0] pc_now = 16'h0;
    logic [15:0] pc = 16'h100;
    logic hreadyout, wake_req, irq, stack_push, pc_load;
    logic [31:0] hrdata;
    logic [15:0] stack_push_pc, pc_load_vec;
    int mismatches = 0;
    int comparisons = 0;
    intc_link_if lnk ();
    intc_ctrl intc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .link(lnk.ctrl), .ext_group0(pins[3:0]),
        .ext_group1(pins[7:4]), .ext_group2(pins[13:8]), .timer0_ovf(pls[0]), .timer1_ovf(pls[1]),
        .timer2_ovf(pls[2]), .uart_rx_done(pls[3]), .uart_tx_done(pls[4]), .adc_start(pls[5]),
        .adc_done(pls[6]), .pwm_period_pass(pls[7]), .base_tick_ovf(pls[8]), .stop_mode(stop_mode),
        .wake_req(wake_req), .irq(irq));
    intc_core_end intc_core_end_inst (.hclk(hclk), .hresetn(hresetn), .link(lnk.core),
        .instr_done(instr_done), .return_from_interrupt_exec(return_from_interrupt_exec), .pc_now(pc_now), .stack_push(stack_push),
        .stack_push_pc(stack_push_pc), .pc_load(pc_load), .pc_load_vec(pc_load_vec));
    intc_link_monitor intc_link_monitor_inst (.hclk(hclk), .hresetn(hresetn), .req(lnk.req),
        .hi(lnk.hi), .src(lnk.src), .vec(lnk.vec), .ack(lnk.ack), .ack_hi(lnk.ack_hi), .return_from_interrupt(lnk.return_from_interrupt));
    // Clock
    always #5 hclk = ~hclk;
    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Wait for hready high at an edge; only the hang guard ends a stuck wait
    task automatic wt();
        do
        begin
            @(posedge hclk);
        end
        while (hreadyout !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // One event: edge on a pin group or a pulse
    task automatic fire(input int i);
        logic [13:0] m;
        m = i == 0 ? 14'h000f : i == 2 ? 14'h00f0 : i == 9 ? 14'h3f00 : 14'h0;
        pins <= pins & ~m;
        pls <= i == 1 ? 9'h001 : i == 3 ? 9'h002 : i == 4 ? 9'h018 : i == 5 ? 9'h004 : i == 6 ? 9'h040 :
            i == 7 ? 9'h080 : i == 8 ? 9'h100 : i == 10 ? 9'h020 : 9'h0;
        @(posedge hclk);
        pins <= pins | m;
        pls <= 9'h0;
        repeat (2) @(posedge hclk);
    endtask
    // One instruction; judges acceptance, push and vector load
    task automatic step(input logic ret, input logic take, input logic [3:0] s);
        logic took;
        // One spare edge: a just-landed write reaches the offer
        @(posedge hclk);
        instr_done <= 1'b1;
        return_from_interrupt_exec <= ret;
        pc_now <= pc;
        @(posedge hclk);
        took = lnk.req & ~ret;
        instr_done <= 1'b0;
        return_from_interrupt_exec <= 1'b0;
        chk(took, take); // offer state
        if (took)
        begin
            #1;
            chk(stack_push, 1'b1); // push first
            chk(stack_push_pc, pc); // pushed pc
            @(posedge hclk);
            #1;
            chk(pc_load, 1'b1); // then load
            chk(pc_load_vec, VEC_TAB[s]); // vector
            chk(lnk.ack_src, s); // chosen source
        end
        @(posedge hclk);
        pc = pc + 16'h1;
    endtask
    task automatic ret();
        step(1'b1, 1'b0, 4'h0); // return
        step(1'b0, 1'b0, 4'h0); // one more first
        repeat (3) @(posedge hclk);
    endtask
    task automatic t_enable();
        rd(OFF_ENABLE, 32'h0); // reset value
        rd(OFF_PRIORITY, 32'h0); // reset value
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0); // unmapped place
        fire(1);
        rd(OFF_FLAGS, 32'h2); // flag still set
        step(1'b0, 1'b0, 4'h0); // nothing enabled
        wr(OFF_ENABLE, 32'h2);
        step(1'b0, 1'b0, 4'h0); // global off
        wr(OFF_ENABLE, 32'h402);
        step(1'b0, 1'b1, SRC_TMR0); // both on
        rd(OFF_FLAGS, 32'h0); // cleared on accept
        ret();
        fire(6);
        rd(OFF_FLAGS, 32'h40); // done sets
        fire(10);
        rd(OFF_FLAGS, 32'h0); // start clears
    endtask
    task automatic t_order();
        logic [10:0] e;
        wr(OFF_RISE_SEL, 32'h3fff);
        wr(OFF_ENABLE, 32'h7ff);
        for (int i = 0; i < 10; i++)
            fire(i);
        for (int i = 0; i < 10; i++)
        begin
            step(1'b0, 1'b1, 4'(i)); // query order
            e = (11'h3ff << (i + 1)) & 11'h3ff;
            e[10] = i <= 4;
            if (i >= 4 && i <= 6)
                e[i] = 1'b1;
            rd(OFF_FLAGS, {21'h0, e}); // hardware clear on accept, except 4 to 6
            wr(OFF_FLAGS, (32'h1 << i) | (i == 4 ? 32'h400 : 32'h0));
            step(1'b0, 1'b0, 4'h0); // same level waits
            ret();
        end
    endtask
    task automatic t_nest();
        wr(OFF_PRIORITY, 32'h8);
        wr(OFF_ENABLE, 32'h40a);
        fire(1);
        step(1'b0, 1'b1, SRC_TMR0); // low level
        rd(OFF_IN_SERVICE, 32'h1); // low set
        fire(3);
        step(1'b0, 1'b1, SRC_TMR1); // high preempts
        rd(OFF_IN_SERVICE, 32'h3); // both set
        fire(1);
        step(1'b0, 1'b0, 4'h0); // low waits
        ret();
        rd(OFF_IN_SERVICE, 32'h1); // high ends
        step(1'b0, 1'b0, 4'h0); // low still busy
        ret();
        rd(OFF_IN_SERVICE, 32'h0); // low ends
        step(1'b0, 1'b1, SRC_TMR0); // kept pending
        ret();
    endtask
    task automatic t_edges();
        wr(OFF_ENABLE, 32'h0);
        wr(OFF_RISE_SEL, 32'h2001);
        wr(OFF_FALL_SEL, 32'h2000);
        pins <= 14'h0;
        repeat (3) @(posedge hclk);
        rd(OFF_FLAGS, 32'h200); // falling pin
        wr(OFF_FLAGS, 32'h7ff);
        pins <= 14'h3fff;
        repeat (3) @(posedge hclk);
        rd(OFF_FLAGS, 32'h201); // rising and dual edge pins
        wr(OFF_FLAGS, 32'h7ff);
    endtask
    task automatic t_wake();
        wr(OFF_RISE_SEL, 32'h3fff);
        wr(OFF_FALL_SEL, 32'h0);
        wr(OFF_ENABLE, 32'h3ff);
        wr(OFF_EV_CLEAR, 32'h7);
        stop_mode <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            fire(i);
            repeat (2) @(posedge hclk);
            chk(wake_req, i == 0 || i == 2 || i >= 8); // wake sources
            wr(OFF_FLAGS, 32'h7ff);
        end
        stop_mode <= 1'b0;
        rd(OFF_EV_STATUS, 32'h1); // wake event
        chk(irq, 1'b0); // masked
        wr(OFF_EV_ENABLE, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b1); // raised
        wr(OFF_EV_CLEAR, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0); // cleared
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_enable();
        t_order();
        t_nest();
        t_edges();
        t_wake();
        tally_and_finish();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
